/* File: bench/front_end_model.sv */
`timescale 1ns/1ps
`default_nettype none
module front_end_model #(
  parameter int DELAY = 20                       // Cycles per zone conversion
) (
  input  wire logic               mclk_in,       // Core clock
  input  wire logic               start_in,      // Conversion request
  input  wire logic signed [11:0] int_temp_in,   // Internal zone temperature
  input  wire logic signed [11:0] rem_temp_in,   // Remote zone temperature
  input  wire logic               fault_in,      // Remote diode open
  output logic                    done_out,      // One-cycle result strobe
  output logic                    zone_out,      // Zone of the result
  output logic signed [11:0]      temp_out,      // Result data
  output logic                    fault_out      // Fault with remote result
);
  // One result cycle; afterwards data shows its inverse so stale values never match
  task automatic give(input logic z, input logic signed [11:0] t);
    repeat (DELAY) @(posedge mclk_in);
    done_out <= 1'b1;
    zone_out <= z;
    temp_out <= t;
    fault_out <= fault_in;
    @(posedge mclk_in);
    done_out <= 1'b0;
    temp_out <= ~t;
    fault_out <= ~fault_in;
  endtask
  // Internal zone first, then remote, after each start pulse
  initial begin
    done_out = 1'b0;
    zone_out = 1'b0;
    temp_out = 12'h000;
    fault_out = 1'b0;
    forever begin
      @(posedge mclk_in);
      if (start_in === 1'b1) begin
        give(1'b0, int_temp_in);
        give(1'b1, rem_temp_in);
      end
    end
  end
endmodule // front_end_model
`default_nettype wire

/* File: bench/temp_result_alarm_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "temp_alarm_defines.vh"
module temp_result_alarm_assertions (
  input wire logic               mclk_in,
  input wire logic               reset_n_in,
  input wire logic        [7:0]  reg_addr_in,
  input wire logic               reg_wr_in,
  input wire logic        [7:0]  reg_wdata_in,
  input wire logic               reg_rd_in,
  input wire logic        [7:0]  reg_rdata_out,
  input wire logic               ara_serviced_in,
  input wire logic               meas_done_in,
  input wire logic               meas_zone_in,
  input wire logic signed [11:0] meas_temp_in,
  input wire logic               meas_fault_in,
  input wire logic               meas_start_out,
  input wire logic               analog_enable_out,
  input wire logic               alert_or_second_thermostat_out,
  input wire logic               alert_or_second_thermostat_oe_out,
  input wire logic               thermostat_output,
  input wire logic               thermostat_oe_out
);
  logic [7:0] cfg_reg;   // Shadow configuration
  logic [7:0] hi_reg;    // Shadow remote high limit
  logic [7:0] thermostat_output_reg; // Shadow remote thermostat limit
  logic [3:0] quiet_reg; // Cycles since a result or write, saturating
  wire        plain_w;   // Remote result inside the unclamped plain range
  assign plain_w = meas_done_in && meas_zone_in && !cfg_reg[`CFG_RANGE_BIT] &&
                   meas_temp_in >= 12'sd0 && meas_temp_in < 12'sd1016;
  // Follow writes so mode and limits are known without peeking inside
  always_ff @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cfg_reg <= `RST_CONFIG;
      hi_reg <= `RST_HIGH_LIMIT;
      thermostat_output_reg <= `RST_THERMOSTAT_OUTPUT_LIMIT;
      quiet_reg <= 4'h0;
    end else begin
      if (meas_done_in || reg_wr_in) quiet_reg <= 4'h0;
      else if (quiet_reg != 4'hf) quiet_reg <= quiet_reg + 4'h1;
      if (reg_wr_in && reg_addr_in == `WR_CONFIG) cfg_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `WR_REM_HIGH_LIMIT) hi_reg <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == `WR_REM_THERMOSTAT_OUTPUT_LIMIT) thermostat_output_reg <= reg_wdata_in;
    end
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  pin_level_a: assert property (!alert_or_second_thermostat_out && !thermostat_output)
    else $error("open-drain level not low");
  alert_set_a: assert property (plain_w && meas_temp_in[10:3] > hi_reg && !cfg_reg[7] &&
    !cfg_reg[5] |-> ##[1:3] alert_or_second_thermostat_oe_out) else $error("alert missing");
  mask_block_a: assert property ($rose(alert_or_second_thermostat_oe_out) && !cfg_reg[5] &&
    !$past(cfg_reg[5]) && !$past(cfg_reg[5], 2) |-> !cfg_reg[7] || !$past(cfg_reg[7]) ||
    !$past(cfg_reg[7], 2)) else $error("masked alert rose");
  alert_release_a: assert property ($fell(alert_or_second_thermostat_oe_out) && !cfg_reg[7] &&
    !cfg_reg[5] && !$past(cfg_reg[5], 3) |-> $past(ara_serviced_in) ||
    $past(ara_serviced_in, 2) || $past(ara_serviced_in, 3)) else $error("alert fell unasked");
  thermostat_output_set_a: assert property (plain_w && meas_temp_in[10:3] > thermostat_output_reg
    |-> ##[1:3] thermostat_oe_out) else $error("thermostat missing");
  thermostat_output_hold_a: assert property ($fell(thermostat_oe_out) |-> quiet_reg <= 4'h4)
    else $error("thermostat fell with no cause");
  lo_zero_a: assert property (reg_rd_in && reg_addr_in == `RD_REM_VALUE_LO |=>
    reg_rdata_out[4:0] == 5'h00) else $error("low byte padding not zero");
  int_lo_a: assert property (reg_rd_in && reg_addr_in == `RD_INT_VALUE_LO |=>
    reg_rdata_out[6:0] == 7'h00) else $error("internal low bits not zero");
  one_shot_a: assert property (reg_wr_in && reg_addr_in == `WR_ONE_SHOT && cfg_reg[6]
    && !analog_enable_out |-> ##[1:3] meas_start_out) else $error("one-shot did not start");
  cover property ($fell(alert_or_second_thermostat_oe_out));
  cover property ($rose(thermostat_oe_out));
  cover property (meas_start_out && cfg_reg[6]);
endmodule // temp_result_alarm_assertions
bind temp_result_alarm temp_result_alarm_assertions temp_result_alarm_assertions_i (.*);
`default_nettype wire

/* File: bench/temp_result_alarm_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "temp_alarm_defines.vh"
module temp_result_alarm_tb_top;
  logic              mclk_in, reset_n_in, reg_wr_in, reg_rd_in, ara_serviced_in;
  logic        [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out, rd_v;
  logic              meas_done_in, meas_zone_in, meas_fault_in, rem_f; // rem_f: model diode open
  logic signed [11:0] meas_temp_in, int_t, rem_t;   // Model temperatures in eighths
  logic              meas_start_out, analog_enable_out, thermostat_output, thermostat_oe_out;
  logic              alert_or_second_thermostat_out, alert_or_second_thermostat_oe_out;
  int                n_mismatch, num_checks, i, c;
  logic        [7:0] ra [9] = '{8'h03, 8'h05, 8'h06, 8'h07, 8'h08, 8'h19, 8'h20, 8'h21, 8'h30};
  logic        [7:0] rv [9] = '{8'h00, 8'h55, 8'h00, 8'h55, 8'h00, 8'h55, 8'h55, 8'h0a, 8'h00};
  logic              fx [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic signed [11:0] ft [6] = '{-12'sd8, 12'sd1100, 12'sd13, -12'sd600, 12'sd1600, 12'sd13};
  logic        [7:0] fh [6] = '{8'h00, 8'h7f, 8'h01, 8'h00, 8'hff, 8'h41};
  logic        [7:0] fl [6] = '{8'h00, 8'h00, 8'ha0, 8'h00, 8'h00, 8'ha0};
  temp_result_alarm temp_result_alarm_i (.*);
  front_end_model front_end_model_i (.mclk_in(mclk_in), .start_in(meas_start_out),
    .int_temp_in(int_t), .rem_temp_in(rem_t), .fault_in(rem_f), .done_out(meas_done_in),
    .zone_out(meas_zone_in), .temp_out(meas_temp_in), .fault_out(meas_fault_in));
  // 200 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #2.5 mclk_in = ~mclk_in;
  end
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: byte %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge mclk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Data is registered, so it is taken just after the strobe's sampling edge
  task automatic rd(input logic [7:0] a);
    @(posedge mclk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge mclk_in);
    reg_rd_in <= 1'b0;
    #1 rd_v = reg_rdata_out;
  endtask
  task automatic ara();
    @(posedge mclk_in);
    ara_serviced_in <= 1'b1;
    @(posedge mclk_in);
    ara_serviced_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    #1;
  endtask
  // Counts conversion starts over a span of cycles
  task automatic cnt(input int n);
    c = 0;
    repeat (n) begin
      @(posedge mclk_in);
      if (meas_start_out === 1'b1) c++;
    end
    #1;
  endtask
  // Two starts: the conversion between them used the current temperatures
  task automatic conv();
    repeat (2) begin
      cnt(1);
      for (int k = 0; k < 200 && c == 0; k++) cnt(1);
      if (c == 0) chk_pin(1'b0, 1'b1);
    end
    cnt(3);
  endtask
  task automatic clean();
    rd(`RD_STATUS);
    rd(`RD_STATUS);
    ara();
  endtask
  task automatic summarize();
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog, well beyond the expected run of some 2k cycles
  initial begin
    #400000;
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    summarize();
  end
  initial begin
    {reset_n_in, reg_wr_in, reg_rd_in, ara_serviced_in} = 4'h0;
    {reg_addr_in, reg_wdata_in} = 16'h0000;
    int_t = 12'sd200;
    rem_f = 1'b0;
    rem_t = 12'sd240;
    n_mismatch = 0;
    num_checks = 0;
    repeat (3) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    for (i = 0; i < 9; i++) begin
      rd(ra[i]);
      chk_byte(rd_v, rv[i]);
    end
    chk_pin(analog_enable_out, 1'b1);
    for (i = 0; i < 6; i++) begin
      wr(`WR_CONFIG, {5'h00, fx[i], 2'h0});
      rem_t = ft[i];
      conv();
      rd(`RD_REM_VALUE_HI);
      chk_byte(rd_v, fh[i]);
      rd(`RD_REM_VALUE_LO);
      chk_byte(rd_v, fl[i]);
    end
    wr(`WR_CONFIG, 8'h00);
    int_t = 12'sd13;
    rem_t = 12'sd13;
    conv();
    rd(`RD_INT_VALUE_HI);
    rem_t = 12'sd14;
    conv();
    rd(`RD_INT_VALUE_LO);
    chk_byte(rd_v, 8'h80);
    rd(`RD_REM_VALUE_HI);
    rd(`RD_REM_VALUE_LO);
    chk_byte(rd_v, 8'hc0);
    rd(`RD_REM_VALUE_HI);
    rem_t = 12'sd13;
    conv();
    rd(`RD_REM_VALUE_LO);
    chk_byte(rd_v, 8'hc0);
    rem_t = 12'sd240;
    conv();
    clean();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b0);
    rem_t = 12'sd720;
    conv();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b1);
    chk_pin(thermostat_oe_out, 1'b1);
    ara();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b1);
    rem_t = 12'sd640;
    conv();
    chk_pin(thermostat_oe_out, 1'b1);
    rem_t = 12'sd560;
    conv();
    chk_pin(thermostat_oe_out, 1'b0);
    ara();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b1);
    rd(`RD_STATUS);
    chk_byte(rd_v & 8'h7c, 8'h10);
    rd(`RD_STATUS);
    chk_byte(rd_v & 8'h7c, 8'h00);
    ara();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b0);
    wr(`WR_CONFIG, 8'h80);
    rem_t = 12'sd720;
    conv();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b0);
    chk_pin(thermostat_oe_out, 1'b1);
    wr(`WR_CONFIG, 8'ha0);
    conv();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b1);
    rem_t = 12'sd640;
    conv();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b1);
    rem_t = 12'sd560;
    conv();
    chk_pin(alert_or_second_thermostat_oe_out, 1'b0);
    clean();
    wr(`WR_CONFIG, 8'h40);
    cnt(100);
    chk_pin(analog_enable_out, 1'b0);
    cnt(100);
    chk_byte(c[7:0], 8'h00);
    rd(`RD_CONFIG);
    chk_byte(rd_v, 8'h40);
    rem_t = 12'sd720;
    wr(`WR_ONE_SHOT, 8'h00);
    cnt(150);
    chk_byte(c[7:0], 8'h01);
    rd(`RD_REM_VALUE_HI);
    chk_byte(rd_v, 8'h5a);
    wr(`WR_REM_THERMOSTAT_OUTPUT_LIMIT, 8'h6e);
    cnt(4);
    chk_pin(thermostat_oe_out, 1'b0);
    wr(`WR_REM_THERMOSTAT_OUTPUT_LIMIT, 8'h50);
    cnt(4);
    chk_pin(thermostat_oe_out, 1'b1);
    // Fault flag survives a read while open, clears once gone
    wr(`WR_CONFIG, 8'h00);
    rem_f = 1'b1;
    conv();
    rd(`RD_STATUS);
    rd(`RD_STATUS);
    chk_byte(rd_v & 8'h04, 8'h04);
    rem_f = 1'b0;
    conv();
    rd(`RD_STATUS);
    chk_byte(rd_v & 8'h04, 8'h04);
    rd(`RD_STATUS);
    chk_byte(rd_v & 8'h04, 8'h00);
    summarize();
  end
endmodule // temp_result_alarm_tb_top
`default_nettype wire

/* File: rtl/temp_alarm_defines.vh */
`ifndef TEMP_ALARM_DEFINES_VH
`define TEMP_ALARM_DEFINES_VH

// Register read offsets
`define RD_INT_VALUE_HI      8'h00
`define RD_REM_VALUE_HI      8'h01
`define RD_STATUS            8'h02
`define RD_CONFIG            8'h03
`define RD_INT_HIGH_LIMIT    8'h05
`define RD_INT_LOW_LIMIT     8'h06
`define RD_REM_HIGH_LIMIT    8'h07
`define RD_REM_LOW_LIMIT     8'h08
`define RD_REM_VALUE_LO      8'h10
`define RD_REM_THERMOSTAT_OUTPUT_LIMIT   8'h19
`define RD_INT_THERMOSTAT_OUTPUT_LIMIT   8'h20
`define RD_THERMOSTAT_OUTPUT_HYST        8'h21
`define RD_INT_VALUE_LO      8'h29

// Register write offsets
`define WR_CONFIG            8'h09
`define WR_INT_HIGH_LIMIT    8'h0b
`define WR_INT_LOW_LIMIT     8'h0c
`define WR_REM_HIGH_LIMIT    8'h0d
`define WR_REM_LOW_LIMIT     8'h0e
`define WR_ONE_SHOT          8'h0f
`define WR_REM_THERMOSTAT_OUTPUT_LIMIT   8'h19
`define WR_INT_THERMOSTAT_OUTPUT_LIMIT   8'h20
`define WR_THERMOSTAT_OUTPUT_HYST        8'h21

// Configuration fields
`define CFG_MASK_BIT         7
`define CFG_STANDBY_BIT      6
`define CFG_THERM2_BIT       5
`define CFG_RANGE_BIT        2

// Status fields
`define ST_BUSY_BIT          7
`define ST_INT_HIGH_BIT      6
`define ST_INT_LOW_BIT       5
`define ST_REM_HIGH_BIT      4
`define ST_REM_LOW_BIT       3
`define ST_FAULT_BIT         2
`define ST_REM_THERMOSTAT_OUTPUT_BIT     1
`define ST_INT_THERMOSTAT_OUTPUT_BIT     0

// Reset values
`define RST_CONFIG           8'h00
`define RST_HIGH_LIMIT       8'h55
`define RST_LOW_LIMIT        8'h00
`define RST_THERMOSTAT_OUTPUT_LIMIT      8'h55
`define RST_THERMOSTAT_OUTPUT_HYST       8'h0a

// Temperature codes, input in eighths of a degree, two's complement
`define TEMP_DEF_MAX_IN      12'sd1016
`define TEMP_EXT_MIN_IN      -12'sd512
`define TEMP_EXT_MAX_IN      12'sd1528
`define TEMP_EXT_OFFSET      12'sd512
`define CODE_DEF_MAX         11'h3f8
`define CODE_EXT_MAX         11'h7f8

`endif

/* File: rtl/temp_code_formatter.v */
`timescale 1ns/1ps
`default_nettype none
`include "temp_alarm_defines.vh"

// Turns a signed eighth-degree reading into the 11-bit result code
module temp_code_formatter #(
  parameter DROP_LSBS = 0                      // Low result bits forced to zero
) (
  input  wire signed [11:0] temp_in,           // Reading in 0.125 degree steps
  input  wire               extended_in,       // Offset-binary range selected
  output reg         [10:0] code_out           // Formatted 11-bit result
);

  reg signed [11:0] shifted;                   // Reading plus range offset
  reg        [10:0] raw;                       // Code before resolution trim

  // Clamp and encode per selected range
  always @* begin
    shifted = temp_in + `TEMP_EXT_OFFSET;
    raw     = 11'h000;
    if (extended_in) begin
      if (temp_in <= `TEMP_EXT_MIN_IN)
        raw = 11'h000;
      else if (temp_in >= `TEMP_EXT_MAX_IN)
        raw = `CODE_EXT_MAX;
      else
        raw = shifted[10:0];
    end else begin
      if (temp_in <= 12'sd0)
        raw = 11'h000;
      else if (temp_in >= `TEMP_DEF_MAX_IN)
        raw = `CODE_DEF_MAX;
      else
        raw = temp_in[10:0];
    end
    // Coarser zones simply lose their bottom bits
    code_out = raw & ~((11'h001 << DROP_LSBS) - 11'h001);
  end

endmodule // temp_code_formatter
`default_nettype wire

/* File: rtl/temp_result_alarm.v */
`timescale 1ns/1ps
`default_nettype none
`include "temp_alarm_defines.vh"

module temp_result_alarm (
  input  wire               mclk_in,            // 200 MHz core clock
  input  wire               reset_n_in,         // Async power-on reset
  input  wire        [7:0]  reg_addr_in,        // Register offset
  input  wire               reg_wr_in,          // Write strobe, one cycle
  input  wire        [7:0]  reg_wdata_in,       // Write data
  input  wire               reg_rd_in,          // Read strobe, one cycle
  output reg         [7:0]  reg_rdata_out,      // Read data, valid cycle after strobe
  input  wire               ara_serviced_in,    // Alert response answered, one cycle
  input  wire               meas_done_in,       // Front end result valid, one cycle
  input  wire               meas_zone_in,       // 0 internal, 1 remote
  input  wire signed [11:0] meas_temp_in,       // Reading in eighth degrees
  input  wire               meas_fault_in,      // Remote diode open with result
  output reg                meas_start_out,     // Start a two-zone conversion
  output reg                analog_enable_out,  // Analog front end powered
  output reg                alert_or_second_thermostat_out, // Pin drive level
  output reg                alert_or_second_thermostat_oe_out, // Pulls pin low
  output reg                thermostat_output,  // Pin drive level
  output reg                thermostat_oe_out   // Pulls pin low
);

  // Software registers
  reg  [7:0]  config_reg;          // Mask, standby, mode, range
  reg  [7:0]  int_high_lim_reg;    // Internal high limit
  reg  [7:0]  int_low_lim_reg;     // Internal low limit
  reg  [7:0]  rem_high_lim_reg;    // Remote high limit
  reg  [7:0]  rem_low_lim_reg;     // Remote low limit
  reg  [7:0]  int_thermostat_output_lim_reg;   // Internal thermostat limit
  reg  [7:0]  rem_thermostat_output_lim_reg;   // Remote thermostat limit
  reg  [7:0]  hyst_reg;            // Shared hysteresis
  // Stored results and interlocked low bytes
  reg  [10:0] int_code_reg;        // Internal result code
  reg  [10:0] rem_code_reg;        // Remote result code
  reg  [2:0]  int_lo_hold_reg;     // Frozen internal low bits
  reg  [2:0]  rem_lo_hold_reg;     // Frozen remote low bits
  reg         int_lock_reg;        // Internal low byte frozen
  reg         rem_lock_reg;        // Remote low byte frozen
  // Conversion control and alarm state
  reg         busy_reg;            // Conversion in flight
  reg         one_shot_reg;        // One-shot request pending
  reg         fault_reg;           // Last remote conversion saw open diode
  reg  [6:2]  status_reg;          // Sticky status flags
  reg         int_thermostat_output_reg;       // Internal thermostat state
  reg         rem_thermostat_output_reg;       // Remote thermostat state
  reg         int_t2_reg;          // Internal second-thermostat state
  reg         rem_t2_reg;          // Remote second-thermostat state
  reg         alert_latch_reg;     // Bus alert latch

  // Formatted codes, derived fields and high bytes
  wire [10:0] fmt_code;            // Formatted incoming reading
  wire [10:0] fmt_code_int;        // Same, internal resolution
  // Field views of the configuration
  wire        ext_range = config_reg[`CFG_RANGE_BIT];
  wire        standby   = config_reg[`CFG_STANDBY_BIT];
  wire        therm2    = config_reg[`CFG_THERM2_BIT];
  wire        masked    = config_reg[`CFG_MASK_BIT];
  // High bytes are the only part compared against limits
  wire [7:0]  int_hi    = int_code_reg[10:3];
  wire [7:0]  rem_hi    = rem_code_reg[10:3];

  // Remote zone keeps full resolution
  temp_code_formatter #(.DROP_LSBS(0)) u_fmt_rem (
    .temp_in     (meas_temp_in),
    .extended_in (ext_range),
    .code_out    (fmt_code)
  );

  // Internal zone truncates to half degrees
  temp_code_formatter #(.DROP_LSBS(2)) u_fmt_int (
    .temp_in     (meas_temp_in),
    .extended_in (ext_range),
    .code_out    (fmt_code_int)
  );

  // Saturating limit minus hysteresis
  // A small limit must not wrap to a release point near the top
  function [7:0] release_point;
    input [7:0] lim;
    input [7:0] hy;
    begin
      release_point = (lim > hy) ? (lim - hy) : 8'h00;
    end
  endfunction

  // Live conditions from stored codes; limits follow at once when rewritten
  wire int_over   = int_hi > int_high_lim_reg;
  wire int_under  = int_hi < int_low_lim_reg;
  wire rem_over   = rem_hi > rem_high_lim_reg;
  wire rem_under  = rem_hi < rem_low_lim_reg;
  // Status bits 6..2 in register order
  wire [6:2] cond = {int_over, int_under, rem_over, rem_under, fault_reg};
  // Every status read is a clearing read
  wire status_clear = reg_rd_in && (reg_addr_in == `RD_STATUS);
  wire out_of_window = |cond;

  // Hysteresis state for all four comparators: both thermostats and both second thermostats
  wire int_thermostat_output_next = int_thermostat_output_reg ?
       !(int_hi < release_point(int_thermostat_output_lim_reg, hyst_reg)) :
       (int_hi > int_thermostat_output_lim_reg);
  wire rem_thermostat_output_next = rem_thermostat_output_reg ?
       !(rem_hi < release_point(rem_thermostat_output_lim_reg, hyst_reg)) :
       (rem_hi > rem_thermostat_output_lim_reg);
  wire int_t2_next = int_t2_reg ?
       !(int_hi < release_point(int_high_lim_reg, hyst_reg)) :
       (int_hi > int_high_lim_reg);
  wire rem_t2_next = rem_t2_reg ?
       !(rem_hi < release_point(rem_high_lim_reg, hyst_reg)) :
       (rem_hi > rem_high_lim_reg);

  // Register writes
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_reg        <= `RST_CONFIG;
      int_high_lim_reg  <= `RST_HIGH_LIMIT;
      int_low_lim_reg   <= `RST_LOW_LIMIT;
      rem_high_lim_reg  <= `RST_HIGH_LIMIT;
      rem_low_lim_reg   <= `RST_LOW_LIMIT;
      int_thermostat_output_lim_reg <= `RST_THERMOSTAT_OUTPUT_LIMIT;
      rem_thermostat_output_lim_reg <= `RST_THERMOSTAT_OUTPUT_LIMIT;
      hyst_reg          <= `RST_THERMOSTAT_OUTPUT_HYST;
    end else if (reg_wr_in) begin
      // Limit writes accepted in any mode, standby included
      case (reg_addr_in)
        `WR_CONFIG:          config_reg        <= reg_wdata_in;
        `WR_INT_HIGH_LIMIT:  int_high_lim_reg  <= reg_wdata_in;
        `WR_INT_LOW_LIMIT:   int_low_lim_reg   <= reg_wdata_in;
        `WR_REM_HIGH_LIMIT:  rem_high_lim_reg  <= reg_wdata_in;
        `WR_REM_LOW_LIMIT:   rem_low_lim_reg   <= reg_wdata_in;
        `WR_INT_THERMOSTAT_OUTPUT_LIMIT: int_thermostat_output_lim_reg <= reg_wdata_in;
        `WR_REM_THERMOSTAT_OUTPUT_LIMIT: rem_thermostat_output_lim_reg <= reg_wdata_in;
        `WR_THERMOSTAT_OUTPUT_HYST:      hyst_reg          <= reg_wdata_in;
        default: ;           // Undefined offsets ignored
      endcase
    end
  end

  // Conversion sequencing: free running, or one-shot in standby
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_reg          <= 1'b0;
      one_shot_reg      <= 1'b0;
      meas_start_out    <= 1'b0;
      analog_enable_out <= 1'b0;
    end else begin
      // Start pulse lasts one cycle unless set below
      meas_start_out <= 1'b0;
      // One-shot only means something in standby; in run it is redundant
      if (reg_wr_in && reg_addr_in == `WR_ONE_SHOT && standby)
        one_shot_reg <= 1'b1;
      // Analog stays on while a one-shot runs, else follows standby
      analog_enable_out <= !standby || busy_reg || one_shot_reg;
      // Idle and allowed: launch both zones
      if (!busy_reg && (!standby || one_shot_reg)) begin
        busy_reg       <= 1'b1;
        meas_start_out <= 1'b1;
        one_shot_reg   <= 1'b0;
      end else if (busy_reg && meas_done_in && meas_zone_in) begin
        busy_reg <= 1'b0; // Remote zone ends the pair
      end
    end
  end

  // Result capture and low byte interlock
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_code_reg    <= 11'h000;
      rem_code_reg    <= 11'h000;
      fault_reg       <= 1'b0;
      int_lo_hold_reg <= 3'h0;
      rem_lo_hold_reg <= 3'h0;
      int_lock_reg    <= 1'b0;
      rem_lock_reg    <= 1'b0;
    end else begin
      // Each zone's strobe captures its own code
      if (meas_done_in && !meas_zone_in)
        int_code_reg <= fmt_code_int;
      if (meas_done_in && meas_zone_in) begin
        rem_code_reg <= fmt_code;
        fault_reg    <= meas_fault_in;
      end
      // Hold copy tracks live value only while unlocked
      if (!int_lock_reg)
        int_lo_hold_reg <= int_code_reg[2:0];
      if (!rem_lock_reg)
        rem_lo_hold_reg <= rem_code_reg[2:0];
      // High byte read freezes, low byte read releases
      if (reg_rd_in && reg_addr_in == `RD_INT_VALUE_HI) begin
        int_lock_reg    <= 1'b1;
        int_lo_hold_reg <= int_code_reg[2:0];
      end else if (reg_rd_in && reg_addr_in == `RD_INT_VALUE_LO)
        int_lock_reg <= 1'b0;
      if (reg_rd_in && reg_addr_in == `RD_REM_VALUE_HI) begin
        rem_lock_reg    <= 1'b1;
        rem_lo_hold_reg <= rem_code_reg[2:0];
      end else if (reg_rd_in && reg_addr_in == `RD_REM_VALUE_LO)
        rem_lock_reg <= 1'b0;
    end
  end

  // Sticky status: a live condition always wins over a clearing read
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      status_reg <= 5'h00;
    // Clearing read keeps only conditions still present
    else if (status_clear)
      status_reg <= cond;
    // Otherwise flags accumulate until read
    else
      status_reg <= status_reg | cond;
  end

  // Thermostat and alert state
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_thermostat_output_reg   <= 1'b0;
      rem_thermostat_output_reg   <= 1'b0;
      int_t2_reg      <= 1'b0;
      rem_t2_reg      <= 1'b0;
      alert_latch_reg <= 1'b0;
    end else begin
      // Comparators run every cycle, standby included
      int_thermostat_output_reg <= int_thermostat_output_next;
      rem_thermostat_output_reg <= rem_thermostat_output_next;
      int_t2_reg    <= int_t2_next;
      rem_t2_reg    <= rem_t2_next;
      // Set is tested first, so it wins over a release
      if (out_of_window && !masked)
        alert_latch_reg <= 1'b1;
      // Release needs the response, no condition and no flags
      else if (ara_serviced_in && !out_of_window && status_reg == 5'h00)
        alert_latch_reg <= 1'b0;
    end
  end

  // Open-drain pins: level fixed low, enable carries the assertion
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      alert_or_second_thermostat_out    <= 1'b0;
      alert_or_second_thermostat_oe_out <= 1'b0;
      thermostat_output                 <= 1'b0;
      thermostat_oe_out                 <= 1'b0;
    end else begin
      alert_or_second_thermostat_out <= 1'b0;
      thermostat_output              <= 1'b0;
      // Mask ignored in thermostat mode
      alert_or_second_thermostat_oe_out <= therm2 ? (int_t2_next || rem_t2_next) :
                                           alert_latch_reg;
      // Thermostat pin never sees the mask
      thermostat_oe_out <= int_thermostat_output_next || rem_thermostat_output_next;
    end
  end

  // Read data, registered one cycle after strobe
  always @(posedge mclk_in or negedge reset_n_in) begin
    if (!reset_n_in)
      reg_rdata_out <= 8'h00;
    else if (reg_rd_in) begin
      case (reg_addr_in)
        `RD_INT_VALUE_HI:    reg_rdata_out <= int_hi;
        `RD_REM_VALUE_HI:    reg_rdata_out <= rem_hi;
        // Low bytes come from the hold copy
        `RD_INT_VALUE_LO:    reg_rdata_out <= {int_lo_hold_reg, 5'h00};
        `RD_REM_VALUE_LO:    reg_rdata_out <= {rem_lo_hold_reg, 5'h00};
        // Busy, sticky flags, then live thermostat states
        `RD_STATUS:          reg_rdata_out <= {busy_reg, status_reg,
                                               rem_thermostat_output_reg, int_thermostat_output_reg};
        `RD_CONFIG:          reg_rdata_out <= config_reg;
        `RD_INT_HIGH_LIMIT:  reg_rdata_out <= int_high_lim_reg;
        `RD_INT_LOW_LIMIT:   reg_rdata_out <= int_low_lim_reg;
        `RD_REM_HIGH_LIMIT:  reg_rdata_out <= rem_high_lim_reg;
        `RD_REM_LOW_LIMIT:   reg_rdata_out <= rem_low_lim_reg;
        `RD_INT_THERMOSTAT_OUTPUT_LIMIT: reg_rdata_out <= int_thermostat_output_lim_reg;
        `RD_REM_THERMOSTAT_OUTPUT_LIMIT: reg_rdata_out <= rem_thermostat_output_lim_reg;
        `RD_THERMOSTAT_OUTPUT_HYST:      reg_rdata_out <= hyst_reg;
        default:             reg_rdata_out <= 8'h00; // Undefined reads zero
      endcase
    end
  end

endmodule // temp_result_alarm
`default_nettype wire
